// [logic/sram_config_mode_control.sv]
`timescale 1ns/1ns
`default_nettype none

module sram_config_mode_control #(
    parameter int DATA_W              = cfg_mode_pkg::DATA_W_DEFAULT,
    parameter int CFG_WORDS           = cfg_mode_pkg::CFG_WORDS_DEFAULT,
    parameter int INIT_CYCLES         = cfg_mode_pkg::INIT_CYCLES_DEFAULT,
    parameter int DCLK_HALF           = cfg_mode_pkg::DCLK_HALF_DEFAULT,
    parameter int RECONFIG_MAX_CYCLES = cfg_mode_pkg::RECONFIG_MAX_CYCLES
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // device pins
    input  wire logic              RECONFIG_N,
    input  wire logic              CHAIN_ENABLE_IN_N,
    output logic                   CHAIN_ENABLE_OUT_N,
    input  wire logic [1:0]        SCHEME_SEL,
    // serial configuration link
    input  wire logic              DCLK_IN,
    input  wire logic              DATA_STROBE,
    input  wire logic              DATA_IN,
    output logic                   DCLK_OUT,
    // configuration memory write port
    output logic                   CFG_WR_VALID,
    output logic [DATA_W-1:0]      CFG_WR_DATA,
    input  wire logic              CFG_WR_READY,
    // mode and status
    output logic                   CONF_DONE,
    output logic                   USER_MODE,
    output logic                   USER_START,
    output logic                   USER_RESET,
    output logic                   IO_OE,
    output logic                   CONFIG_ERROR,
    output logic                   OVERRUN
);

    localparam int BIT_W  = (DATA_W > 1) ? $clog2(DATA_W) : 1;
    localparam int WORD_W = $clog2(CFG_WORDS + 1);
    localparam int INIT_W = $clog2(INIT_CYCLES + 1);
    localparam int DIV_W  = $clog2(DCLK_HALF + 1);
    localparam int WD_W   = cfg_mode_pkg::WDOG_W;

    localparam logic [BIT_W-1:0]  BIT_LAST  = BIT_W'(DATA_W - 1);
    localparam logic [WORD_W-1:0] WORD_LAST = WORD_W'(CFG_WORDS - 1);
    localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(DCLK_HALF - 1);
    localparam logic [WD_W-1:0]   WD_LAST   = WD_W'(RECONFIG_MAX_CYCLES - 1);

    typedef struct packed {
        cfg_mode_pkg::mode_state_t state;
        logic [1:0]                scheme;
        // synchronisers
        logic                      rc_s1;
        logic                      rc_s2;
        logic                      ce_s1;
        logic                      ce_s2;
        logic [1:0]                sel_s1;
        logic [1:0]                sel_s2;
        logic                      dclk_s1;
        logic                      dclk_s2;
        logic                      dclk_s3;
        logic                      strb_s1;
        logic                      strb_s2;
        logic                      strb_s3;
        logic                      data_s1;
        logic                      data_s2;
        // deserialiser and divider
        logic [DATA_W-1:0]         shift;
        logic [BIT_W-1:0]          bit_cnt;
        logic [WORD_W-1:0]         word_cnt;
        logic [DIV_W-1:0]          div_cnt;
        logic                      dclk_out;
        // two-entry buffer
        logic [DATA_W-1:0]         head;
        logic                      head_v;
        logic [DATA_W-1:0]         tail;
        logic                      tail_v;
        // sequencing
        logic [INIT_W-1:0]         init_cnt;
        logic [WD_W-1:0]           wdog;
        logic                      chain_out_n;
        logic                      conf_done;
        logic                      user_mode;
        logic                      user_start;
        logic                      user_reset;
        logic                      io_oe;
        logic                      error;
        logic                      overrun;
    } state_t;

    state_t q_ff;
    state_t nxt_q;

    // ========================================================================
    // next state
    // ========================================================================
    always_comb begin
        logic              loading;
        logic              bit_take;
        logic              word_done;
        logic              push;
        logic              pop;
        logic [DATA_W-1:0] word;

        nxt_q = q_ff;
        loading = 1'b0;
        bit_take = 1'b0;
        word_done = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        word = {q_ff.shift[DATA_W-2:0], q_ff.data_s2};

        nxt_q.rc_s1   = RECONFIG_N;
        nxt_q.rc_s2   = q_ff.rc_s1;
        nxt_q.ce_s1   = CHAIN_ENABLE_IN_N;
        nxt_q.ce_s2   = q_ff.ce_s1;
        nxt_q.sel_s1  = SCHEME_SEL;
        nxt_q.sel_s2  = q_ff.sel_s1;
        nxt_q.dclk_s1 = DCLK_IN;
        nxt_q.dclk_s2 = q_ff.dclk_s1;
        nxt_q.dclk_s3 = q_ff.dclk_s2;
        nxt_q.strb_s1 = DATA_STROBE;
        nxt_q.strb_s2 = q_ff.strb_s1;
        nxt_q.strb_s3 = q_ff.strb_s2;
        nxt_q.data_s1 = DATA_IN;
        nxt_q.data_s2 = q_ff.data_s1;
        nxt_q.user_start = 1'b0;

        // bits are taken only while this device holds the chain enable
        loading = q_ff.state == cfg_mode_pkg::ST_LOAD && !q_ff.ce_s2;

        // scheme-specific bit sampling
        case (q_ff.scheme)
            cfg_mode_pkg::SCHEME_PASSIVE_SERIAL: begin
                bit_take = loading && q_ff.dclk_s2 && !q_ff.dclk_s3;
            end
            cfg_mode_pkg::SCHEME_PASSIVE_SERIAL_ASYNC: begin
                bit_take = loading && q_ff.strb_s2 && !q_ff.strb_s3;
            end
            default: begin
                // own clock halts while the buffer is full: no word lost
                if (loading && !q_ff.tail_v) begin
                    if (q_ff.div_cnt == DIV_LAST) begin
                        nxt_q.div_cnt  = '0;
                        nxt_q.dclk_out = !q_ff.dclk_out;
                        // sample at the falling edge, data settled by then
                        bit_take = q_ff.dclk_out;
                    end else begin
                        nxt_q.div_cnt = q_ff.div_cnt + DIV_W'(1);
                    end
                end
            end
        endcase

        if (bit_take) begin
            nxt_q.shift = word;
            if (q_ff.bit_cnt == BIT_LAST) begin
                nxt_q.bit_cnt = '0;
                word_done = 1'b1;
            end else begin
                nxt_q.bit_cnt = q_ff.bit_cnt + BIT_W'(1);
            end
        end

        // a passive source cannot be stalled: a full buffer drops the word
        push = word_done && !q_ff.tail_v;
        if (word_done && q_ff.tail_v) begin
            nxt_q.overrun = 1'b1;
        end

        // ====================================================================
        // two-entry buffer: pop first, then push
        // ====================================================================
        pop = q_ff.head_v && CFG_WR_READY;
        if (pop) begin
            if (q_ff.tail_v) begin
                nxt_q.head   = q_ff.tail;
                nxt_q.tail_v = 1'b0;
            end else begin
                nxt_q.head_v = 1'b0;
            end
        end
        if (push) begin
            if (!nxt_q.head_v) begin
                nxt_q.head   = word;
                nxt_q.head_v = 1'b1;
            end else begin
                nxt_q.tail   = word;
                nxt_q.tail_v = 1'b1;
            end
        end

        // ====================================================================
        // mode sequencer
        // ====================================================================
        case (q_ff.state)
            cfg_mode_pkg::ST_WAIT: begin
                // command mode after power-up: a full load is required
                if (!q_ff.ce_s2) begin
                    nxt_q.state  = cfg_mode_pkg::ST_LOAD;
                    nxt_q.scheme = q_ff.sel_s2;
                    nxt_q.wdog   = '0;
                end
            end
            cfg_mode_pkg::ST_LOAD: begin
                if (push) begin
                    nxt_q.word_cnt = q_ff.word_cnt + WORD_W'(1);
                    if (q_ff.word_cnt == WORD_LAST) begin
                        nxt_q.state = cfg_mode_pkg::ST_DRAIN;
                    end
                end
            end
            cfg_mode_pkg::ST_DRAIN: begin
                if (!q_ff.head_v && !q_ff.tail_v) begin
                    nxt_q.state       = cfg_mode_pkg::ST_INIT;
                    nxt_q.init_cnt    = '0;
                    nxt_q.conf_done   = 1'b1;
                    nxt_q.chain_out_n = 1'b0;
                end
            end
            cfg_mode_pkg::ST_INIT: begin
                // user registers stay cleared until the count ends
                if (q_ff.init_cnt == INIT_LAST) begin
                    nxt_q.state      = cfg_mode_pkg::ST_USER;
                    nxt_q.user_reset = 1'b0;
                    nxt_q.io_oe      = 1'b1;
                    nxt_q.user_mode  = 1'b1;
                    nxt_q.user_start = 1'b1;
                end else begin
                    nxt_q.init_cnt = q_ff.init_cnt + INIT_W'(1);
                end
            end
            cfg_mode_pkg::ST_USER: begin
            end
            cfg_mode_pkg::ST_FAIL: begin
            end
            default: begin
                nxt_q.state = cfg_mode_pkg::ST_WAIT;
            end
        endcase

        // load-to-user bound; a stuck load ends in a held failure
        if (q_ff.state == cfg_mode_pkg::ST_LOAD ||
            q_ff.state == cfg_mode_pkg::ST_DRAIN ||
            q_ff.state == cfg_mode_pkg::ST_INIT) begin
            if (q_ff.wdog == WD_LAST) begin
                nxt_q.state = cfg_mode_pkg::ST_FAIL;
                nxt_q.error = 1'b1;
                nxt_q.user_start = 1'b0;
                nxt_q.user_mode  = 1'b0;
                nxt_q.user_reset = 1'b1;
                nxt_q.io_oe      = 1'b0;
            end else begin
                nxt_q.wdog = q_ff.wdog + WD_W'(1);
            end
        end

        // pin-forced command mode overrides everything
        if (!q_ff.rc_s2) begin
            nxt_q.state       = cfg_mode_pkg::ST_WAIT;
            nxt_q.bit_cnt     = '0;
            nxt_q.word_cnt    = '0;
            nxt_q.div_cnt     = '0;
            nxt_q.dclk_out    = 1'b0;
            nxt_q.head_v      = 1'b0;
            nxt_q.tail_v      = 1'b0;
            nxt_q.init_cnt    = '0;
            nxt_q.wdog        = '0;
            nxt_q.chain_out_n = 1'b1;
            nxt_q.conf_done   = 1'b0;
            nxt_q.user_mode   = 1'b0;
            nxt_q.user_start  = 1'b0;
            nxt_q.user_reset  = 1'b1;
            nxt_q.io_oe       = 1'b0;
            nxt_q.error       = 1'b0;
            nxt_q.overrun     = 1'b0;
        end
    end

    // ========================================================================
    // state register
    // ========================================================================
    always_ff @(posedge CLK) begin
        if (RST) begin
            q_ff             <= '0;
            q_ff.rc_s1       <= cfg_mode_pkg::RECONFIG_N_RST;
            q_ff.rc_s2       <= cfg_mode_pkg::RECONFIG_N_RST;
            q_ff.ce_s1       <= cfg_mode_pkg::CHAIN_OUT_N_RST;
            q_ff.ce_s2       <= cfg_mode_pkg::CHAIN_OUT_N_RST;
            q_ff.user_reset  <= cfg_mode_pkg::USER_RESET_RST;
            q_ff.chain_out_n <= cfg_mode_pkg::CHAIN_OUT_N_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    assign CHAIN_ENABLE_OUT_N = q_ff.chain_out_n;
    assign DCLK_OUT           = q_ff.dclk_out;
    assign CFG_WR_VALID       = q_ff.head_v;
    assign CFG_WR_DATA        = q_ff.head;
    assign CONF_DONE          = q_ff.conf_done;
    assign USER_MODE          = q_ff.user_mode;
    assign USER_START         = q_ff.user_start;
    assign USER_RESET         = q_ff.user_reset;
    assign IO_OE              = q_ff.io_oe;
    assign CONFIG_ERROR       = q_ff.error;
    assign OVERRUN            = q_ff.overrun;

endmodule // sram_config_mode_control

`default_nettype wire

// [pkg/cfg_mode_pkg.sv]
`default_nettype none
package cfg_mode_pkg;

    // ========================================================================
    // configuration scheme select codes
    // ========================================================================
    localparam logic [1:0] SCHEME_CONFIG_DEVICE        = 2'h0;
    localparam logic [1:0] SCHEME_PASSIVE_SERIAL       = 2'h1;
    localparam logic [1:0] SCHEME_PASSIVE_SERIAL_ASYNC = 2'h2;

    // ========================================================================
    // mode sequencer states
    // ========================================================================
    typedef enum logic [2:0] {
        ST_WAIT  = 3'h0,
        ST_LOAD  = 3'h1,
        ST_DRAIN = 3'h2,
        ST_INIT  = 3'h3,
        ST_USER  = 3'h4,
        ST_FAIL  = 3'h5
    } mode_state_t;

    // ========================================================================
    // timing
    // ========================================================================
    localparam int CLK_MHZ            = 250;
    localparam int RECONFIG_MAX_MS    = 100;
    // longest time in CLK cycles: exact product, nothing rounds
    localparam int RECONFIG_MAX_CYCLES = RECONFIG_MAX_MS * 1000 * CLK_MHZ;
    localparam int WDOG_W             = 32;

    // ========================================================================
    // structural defaults
    // ========================================================================
    localparam int DATA_W_DEFAULT      = 8;
    localparam int CFG_WORDS_DEFAULT   = 16;
    localparam int INIT_CYCLES_DEFAULT = 16;
    localparam int DCLK_HALF_DEFAULT   = 4;

    // ========================================================================
    // reset values of the non-zero outputs and synchronisers
    // ========================================================================
    localparam logic USER_RESET_RST  = 1'h1;
    localparam logic CHAIN_OUT_N_RST = 1'h1;
    localparam logic RECONFIG_N_RST  = 1'h1;

endpackage

`default_nettype wire

// [bench/sram_config_mode_control_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// mode sequencer checker
module cfg_mode_checker #(
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic              CLK,
    input wire logic              RST,
    // pins, write port and status
    input wire logic              RECONFIG_N,
    input wire logic              CHAIN_ENABLE_OUT_N,
    input wire logic              CFG_WR_VALID,
    input wire logic [DATA_W-1:0] CFG_WR_DATA,
    input wire logic              CFG_WR_READY,
    input wire logic              CONF_DONE,
    input wire logic              USER_MODE,
    input wire logic              USER_START,
    input wire logic              USER_RESET,
    input wire logic              IO_OE,
    input wire logic              CONFIG_ERROR,
    input wire logic              OVERRUN
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    chk_pins_user: assert property (IO_OE == USER_MODE)
        else $error("pin enable apart from user mode");
    chk_regs_clear: assert property (USER_RESET == !USER_MODE)
        else $error("user clear apart from user mode");
    chk_start_entry: assert property (USER_START |-> $rose(USER_MODE))
        else $error("start pulse without entry");
    chk_entry_start: assert property ($rose(USER_MODE) |-> USER_START)
        else $error("entry without start pulse");
    chk_done_first: assert property (USER_MODE |-> CONF_DONE)
        else $error("user mode before load done");
    chk_chain_done: assert property (CHAIN_ENABLE_OUT_N == !CONF_DONE)
        else $error("chain output apart from done");
    chk_reconfig_exit: assert property (
        (!RECONFIG_N) [*4] |-> !USER_MODE && !CONF_DONE && !OVERRUN)
        else $error("reconfigure did not reach command mode");
    chk_err_cmd: assert property (CONFIG_ERROR |-> !USER_MODE)
        else $error("user mode after timeout");
    // a pending reconfigure flushes the buffer, so it is left out
    chk_word_hold: assert property (
        CFG_WR_VALID && !CFG_WR_READY && RECONFIG_N |=>
        CFG_WR_VALID && $stable(CFG_WR_DATA))
        else $error("word changed while stalled");
    cov_user: cover property (USER_START);
    cov_overrun: cover property ($rose(OVERRUN));
    cov_timeout: cover property ($rose(CONFIG_ERROR));
endmodule // cfg_mode_checker
bind sram_config_mode_control cfg_mode_checker #(.DATA_W(DATA_W)) u_chk (
    .CLK(CLK), .RST(RST), .RECONFIG_N(RECONFIG_N), .IO_OE(IO_OE),
    .CHAIN_ENABLE_OUT_N(CHAIN_ENABLE_OUT_N), .CFG_WR_VALID(CFG_WR_VALID),
    .CFG_WR_DATA(CFG_WR_DATA), .CFG_WR_READY(CFG_WR_READY),
    .CONF_DONE(CONF_DONE), .USER_MODE(USER_MODE), .USER_START(USER_START),
    .USER_RESET(USER_RESET), .CONFIG_ERROR(CONFIG_ERROR), .OVERRUN(OVERRUN)
);
`default_nettype wire

// [bench/cfg_source_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// serial configuration source
module cfg_source_model (
    // clock
    input  wire logic       clk,
    // scheme and device bit clock
    input  wire logic [1:0] scheme,
    input  wire logic       dclk_out,
    // serial lines
    output logic            dclk_in,
    output logic            data_strobe,
    output logic            data_in
);
    logic      bits_q[$];
    logic      dclk_out_d = 1'b0;
    int        ph = 0;
    int        hold = 0;
    wire logic from_dev = (scheme == 2'h0) || (scheme == 2'h3);
    task automatic push_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            bits_q.push_back(w[i]); // msb leaves first
        end
    endtask
    initial {dclk_in, data_strobe, data_in} = 3'h0;
    always @(posedge clk) begin
        dclk_out_d <= dclk_out;
        if (from_dev) begin
            dclk_in <= 1'b0;
            data_strobe <= 1'b0;
            if (dclk_out && !dclk_out_d && bits_q.size() != 0) begin
                data_in <= bits_q.pop_front(); // change after the rise
            end else if (!dclk_out && dclk_out_d) begin
                hold <= 3;
            end else if (hold != 0) begin
                hold <= hold - 1;
            end else if (bits_q.size() == 0 && !dclk_out) begin
                data_in <= ~data_in; // idle line shows no stale bit
            end
        end else if (ph == 0 && bits_q.size() == 0) begin
            data_in <= ~data_in;
        end else begin
            // bit stands 3 clocks before and 7 after its clock rise
            ph <= (ph + 1) % 10;
            if (ph == 0) data_in <= bits_q.pop_front();
            dclk_in <= (ph >= 3 && ph <= 7) && (scheme == 2'h1);
            data_strobe <= (ph >= 3 && ph <= 7) && (scheme == 2'h2);
        end
    end
endmodule // cfg_source_model
`default_nettype wire

// [bench/tb_sram_config_mode_control.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// load sequence bench
module tb_sram_config_mode_control;
    localparam int WORDS = 4;
    localparam int MAXC = 1000;
    logic       clk, rst, reconfig_n, chain_in_n, chain_out_n, dclk_in;
    logic       data_strobe, data_in, dclk_out, wr_valid, wr_ready, stall;
    logic       conf_done, user_mode, user_start, user_reset, io_oe;
    logic       config_error, overrun;
    logic [1:0] scheme;
    logic [7:0] wr_data;
    logic [7:0] exp_q[$];
    logic [7:0] ew;
    logic       dclk_prev = 1'h0;
    int         n_mismatch, checks, n_start, cyc, t0, st, n_rise, r0, nb;
    sram_config_mode_control #(
        .DATA_W(8), .CFG_WORDS(WORDS), .INIT_CYCLES(4), .DCLK_HALF(4),
        .RECONFIG_MAX_CYCLES(MAXC)
    ) u_dut (
        .CLK(clk), .RST(rst), .RECONFIG_N(reconfig_n),
        .CHAIN_ENABLE_IN_N(chain_in_n), .CHAIN_ENABLE_OUT_N(chain_out_n),
        .SCHEME_SEL(scheme), .DCLK_IN(dclk_in), .DATA_STROBE(data_strobe),
        .DATA_IN(data_in), .DCLK_OUT(dclk_out), .CFG_WR_VALID(wr_valid),
        .CFG_WR_DATA(wr_data), .CFG_WR_READY(wr_ready),
        .CONF_DONE(conf_done), .USER_MODE(user_mode), .USER_START(user_start),
        .USER_RESET(user_reset), .IO_OE(io_oe), .CONFIG_ERROR(config_error),
        .OVERRUN(overrun)
    );
    cfg_source_model u_src (
        .clk(clk), .scheme(scheme), .dclk_out(dclk_out), .dclk_in(dclk_in),
        .data_strobe(data_strobe), .data_in(data_in)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d in %0d checks", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic push_load(input int n, input int kept);
        logic [7:0] w;
        for (int i = 0; i < n; i++) begin
            w = 8'($urandom);
            if (i < kept) exp_q.push_back(w);
            u_src.push_word(w);
        end
    endtask
    task automatic reconfig(input logic [1:0] s);
        @(posedge clk);
        reconfig_n <= 1'b0;
        scheme <= s;
        repeat (6) @(negedge clk);
        check({user_mode, io_oe, conf_done}, 3'h0, "command mode");
        check({chain_out_n, config_error, overrun}, 3'h4, "cleared");
        @(posedge clk);
        reconfig_n <= 1'b1;
    endtask
    // random stalls on the write port; results checked in arrival order
    always @(posedge clk) begin
        cyc <= cyc + 1;
        wr_ready <= !stall && ($urandom % 3 != 0);
        if (user_start === 1'b1) n_start <= n_start + 1;
        dclk_prev <= dclk_out;
        if (dclk_out === 1'b1 && dclk_prev === 1'b0) n_rise <= n_rise + 1;
        if (rst === 1'b0 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            ew = exp_q.size() ? exp_q.pop_front() : 8'hXX;
            check(wr_data, ew, "word");
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run;
    end
    initial begin
        {n_mismatch, checks, n_start, cyc, n_rise} = {5{32'h0}};
        void'($urandom(7));
        {rst, reconfig_n, chain_in_n, stall, wr_ready} = 5'h1C;
        scheme = 2'h1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        check({user_reset, chain_out_n}, 2'h3, "reset high");
        check({io_oe, user_mode, conf_done}, 3'h0, "reset low");
        @(posedge clk);
        u_src.push_word(8'hA5);
        repeat (100) @(negedge clk);
        check({conf_done, chain_out_n, wr_valid}, 3'h2, "chain off");
        for (int s = 0; s < 4; s++) begin
            reconfig(2'(s));
            // the device scheme clocks at once, so its data must wait ready
            if (s == 0 || s == 3) push_load(WORDS, WORDS);
            chain_in_n <= 1'b0;
            t0 = cyc;
            st = n_start;
            r0 = n_rise;
            nb = (s == 0 || s == 3) ? 8 * WORDS : 0;
            repeat (6) @(posedge clk);
            if (s == 1 || s == 2) push_load(WORDS, WORDS);
            for (int i = 0; i < MAXC && user_start !== 1'b1; i++)
                @(negedge clk);
            check(user_start, 1'b1, "user start");
            check(cyc - t0 < MAXC, 1'b1, "load time");
            @(negedge clk);
            check({user_mode, io_oe, user_reset}, 3'h6, "user entry");
            check({conf_done, chain_out_n}, 2'h2, "chain passed");
            check(exp_q.size(), 0, "words left");
            check(n_start - st, 1, "start count");
            check(n_rise - r0, nb, "bit clocks");
            check(dclk_out, 1'b0, "bit clock idle");
        end
        reconfig(2'h2);
        stall <= 1'b1;
        push_load(3, 2);
        for (int i = 0; i < MAXC && overrun !== 1'b1; i++) @(negedge clk);
        check({overrun, wr_valid}, 2'h3, "full buffer refuses");
        @(posedge clk);
        stall <= 1'b0;
        for (int i = 0; i < 2 * MAXC && config_error !== 1'b1; i++)
            @(negedge clk);
        check({config_error, user_mode, io_oe}, 3'h4, "timed out");
        check(exp_q.size(), 0, "buffered words");
        reconfig(2'h1);
        complete_run;
    end
endmodule // tb_sram_config_mode_control
`default_nettype wire
